// [lui_host_serial_port.v]
// Host control port of a line interface unit: serial slave and mode selects.
`timescale 1ns/1ns
`default_nettype none
`include "lui_port_consts.vh"
module lui_host_serial_port (
  // Clock and control
  input  wire        i_sys_clk,
  input  wire        i_resetn,
  input  wire        i_ce,
  // Interface strap pins
  input  wire        i_port_select_hi,
  input  wire        i_port_select_lo,
  input  wire        i_parallel_timing_style,
  input  wire        i_input_edge_select,
  input  wire        i_output_edge_select,
  // Serial host pins
  input  wire        i_cs_n,
  input  wire        i_sclk,
  input  wire        i_serial_in,
  output reg         o_serial_out,
  output wire        o_serial_out_oe,
  // Mode indications
  output wire        o_serial_mode,
  output wire        o_parallel_mode,
  output wire        o_parallel_muxed,
  output wire        o_parallel_style_alt,
  // Line-side status inputs
  input  wire [7:0]  i_line_status,
  input  wire [7:0]  i_receive_info_1,
  input  wire [7:0]  i_receive_info_2,
  input  wire [7:0]  i_error_count_1,
  input  wire [7:0]  i_error_count_2,
  // Register contents to the line logic
  output wire [175:0] o_regs
);
  localparam ST_IDLE = 2'd0;
  localparam ST_CMD  = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_DONE = 2'd3;

  wire cs_n_s;
  wire sclk_s;
  wire serial_in_s;
  wire bsh_s;
  wire bsl_s;
  wire pts_s;
  wire ies_s;
  wire oes_s;

  // Every pin from outside the clock domain passes two flops.
  lui_sync2 u_sync_cs   (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_ce(i_ce),
                         .i_async(i_cs_n), .o_sync(cs_n_s));
  lui_sync2 u_sync_sclk (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_ce(i_ce),
                         .i_async(i_sclk), .o_sync(sclk_s));
  lui_sync2 u_sync_serial_in (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_ce(i_ce),
                              .i_async(i_serial_in), .o_sync(serial_in_s));
  lui_sync2 u_sync_bsh  (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_ce(i_ce),
                         .i_async(i_port_select_hi), .o_sync(bsh_s));
  lui_sync2 u_sync_bsl  (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_ce(i_ce),
                         .i_async(i_port_select_lo), .o_sync(bsl_s));
  lui_sync2 u_sync_pts  (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_ce(i_ce),
                         .i_async(i_parallel_timing_style), .o_sync(pts_s));
  lui_sync2 u_sync_ies  (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_ce(i_ce),
                         .i_async(i_input_edge_select), .o_sync(ies_s));
  lui_sync2 u_sync_oes  (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_ce(i_ce),
                         .i_async(i_output_edge_select), .o_sync(oes_s));

  // Mode decode from the strap pins.
  assign o_serial_mode        = bsh_s & ~bsl_s;
  assign o_parallel_mode      = ~bsh_s;
  assign o_parallel_muxed     = ~bsh_s & ~bsl_s;
  assign o_parallel_style_alt = ~bsh_s & pts_s;

  reg        sclk_d_r;
  reg [1:0]  state_r;
  reg [1:0]  state_nxt;
  reg [7:0]  sh_in_r;
  reg [2:0]  in_cnt_r;
  reg [7:0]  sh_out_r;
  reg [2:0]  out_cnt_r;
  reg        rd_r;
  reg        burst_r;
  reg [4:0]  addr_r;
  reg        wr_en_r;
  reg [4:0]  wr_addr_r;
  reg [7:0]  wr_data_r;
  reg        out_live_r;
  reg        load_pend_r;
  wire [7:0] rd_data;

  wire rise      = sclk_s & ~sclk_d_r;
  wire fall      = ~sclk_s & sclk_d_r;
  wire active    = o_serial_mode & ~cs_n_s;
  wire in_edge   = ies_s ? fall : rise;
  wire out_edge  = oes_s ? rise : fall;
  wire [7:0] byte_in = {serial_in_s, sh_in_r[7:1]};
  wire byte_done = active && in_edge && (in_cnt_r == 3'd7);

  lui_reg_file u_regs (
    .i_sys_clk        (i_sys_clk),
    .i_resetn         (i_resetn),
    .i_ce             (i_ce),
    .i_wr_en          (wr_en_r),
    .i_wr_addr        (wr_addr_r),
    .i_wr_data        (wr_data_r),
    .i_rd_addr        (addr_r),
    .o_rd_data        (rd_data),
    .i_line_status    (i_line_status),
    .i_receive_info_1 (i_receive_info_1),
    .i_receive_info_2 (i_receive_info_2),
    .i_error_count_1  (i_error_count_1),
    .i_error_count_2  (i_error_count_2),
    .o_regs           (o_regs)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (active) begin
          state_nxt = ST_CMD;
        end
      end
      ST_CMD: begin
        if (byte_done) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (byte_done && !burst_r) begin
          state_nxt = ST_DONE;
        end else if (byte_done && rd_r && addr_r == `ADDR_LAST_REG) begin
          state_nxt = ST_DONE;
        end else if (byte_done && !rd_r && addr_r == `ADDR_BURST_WRITE_LAST) begin
          state_nxt = ST_DONE;
        end
      end
      default: begin
        state_nxt = ST_DONE;
      end
    endcase
    if (!active) begin
      state_nxt = ST_IDLE;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      sclk_d_r    <= 1'b0;
      state_r     <= ST_IDLE;
      sh_in_r     <= 8'h00;
      in_cnt_r    <= 3'd0;
      sh_out_r    <= 8'h00;
      out_cnt_r   <= 3'd0;
      rd_r        <= 1'b0;
      burst_r     <= 1'b0;
      addr_r      <= 5'h00;
      wr_en_r     <= 1'b0;
      wr_addr_r   <= 5'h00;
      wr_data_r   <= 8'h00;
      out_live_r  <= 1'b0;
      load_pend_r <= 1'b0;
      o_serial_out <= 1'b0;
    end else if (i_ce) begin
      sclk_d_r <= sclk_s;
      state_r  <= state_nxt;
      wr_en_r  <= 1'b0;
      if (!active || state_r == ST_IDLE) begin
        // Chip select high clears the bit counters and the output flags; command, address and shift-in bits keep their values.
        in_cnt_r    <= 3'd0;
        out_cnt_r   <= 3'd0;
        out_live_r  <= 1'b0;
        load_pend_r <= 1'b0;
      end else begin
        if (in_edge && state_r != ST_DONE) begin
          sh_in_r  <= byte_in;
          in_cnt_r <= in_cnt_r + 3'd1;
        end
        if (byte_done && state_r == ST_CMD) begin
          rd_r    <= byte_in[`CMD_DIR_BIT];
          burst_r <= byte_in[`CMD_BURST_BIT];
          // Burst always begins at register zero.
          addr_r  <= byte_in[`CMD_BURST_BIT] ? 5'h00 :
                     byte_in[`CMD_ADDR_LSB+4:`CMD_ADDR_LSB];
          load_pend_r <= byte_in[`CMD_DIR_BIT];
        end
        if (byte_done && state_r == ST_DATA) begin
          if (!rd_r) begin
            wr_en_r   <= 1'b1;
            wr_addr_r <= addr_r;
            wr_data_r <= byte_in;
          end
          if (burst_r) begin
            addr_r <= addr_r + 5'd1;
            load_pend_r <= rd_r && (addr_r != `ADDR_LAST_REG);
          end
        end
        // Read data shifts out LSB first on the selected output edge.
        if (out_edge && state_r == ST_DATA && rd_r) begin
          if (out_cnt_r == 3'd0 && load_pend_r) begin
            o_serial_out <= rd_data[0];
            sh_out_r     <= {1'b0, rd_data[7:1]};
            out_live_r   <= 1'b1;
            load_pend_r  <= 1'b0;
            out_cnt_r    <= 3'd1;
          end else if (out_cnt_r != 3'd0) begin
            o_serial_out <= sh_out_r[0];
            sh_out_r     <= {1'b0, sh_out_r[7:1]};
            out_cnt_r    <= out_cnt_r + 3'd1;
          end
        end
      end
    end
  end

  assign o_serial_out_oe = active & out_live_r;
endmodule // lui_host_serial_port
`default_nettype wire

// [lui_port_consts.vh]
// Constants for the line interface host control port.
`ifndef LUI_PORT_CONSTS_VH
`define LUI_PORT_CONSTS_VH

`define ADDR_COMMON_CONTROL_1     5'h00
`define ADDR_COMMON_CONTROL_2     5'h01
`define ADDR_COMMON_CONTROL_3     5'h02
`define ADDR_COMMON_CONTROL_4     5'h03
`define ADDR_COMMON_CONTROL_5     5'h04
`define ADDR_COMMON_CONTROL_6     5'h05
`define ADDR_LINE_STATUS          5'h06
`define ADDR_INTERRUPT_MASK       5'h07
`define ADDR_RECEIVE_INFO_1       5'h08
`define ADDR_RECEIVE_INFO_2       5'h09
`define ADDR_INBAND_CODE_CONTROL  5'h0a
`define ADDR_TX_CODE_DEF_1        5'h0b
`define ADDR_TX_CODE_DEF_2        5'h0c
`define ADDR_RX_LOOPUP_CODE_1     5'h0d
`define ADDR_RX_LOOPUP_CODE_2     5'h0e
`define ADDR_RX_LOOPDOWN_CODE_1   5'h0f
`define ADDR_RX_LOOPDOWN_CODE_2   5'h10
`define ADDR_ERROR_COUNT_1        5'h11
`define ADDR_ERROR_COUNT_2        5'h12
`define ADDR_FACTORY_CHECK_1      5'h13
`define ADDR_FACTORY_CHECK_2      5'h14
`define ADDR_FACTORY_CHECK_3      5'h15
`define ADDR_LAST_REG             5'h15
`define ADDR_BURST_WRITE_LAST     5'h16
`define REG_COUNT                 22

`define CMD_DIR_BIT               0
`define CMD_ADDR_LSB              1
`define CMD_BURST_BIT             7
`define REG_RESET_VALUE           8'h00

`endif

// [lui_sync2.v]
// Two-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
module lui_sync2 (
  // Clock and control
  input  wire i_sys_clk,
  input  wire i_resetn,
  input  wire i_ce,
  // Data
  input  wire i_async,
  output wire o_sync
);
  reg meta_r;
  reg sync_r;

  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else if (i_ce) begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule // lui_sync2
`default_nettype wire

// [lui_reg_file.v]
// Byte-wide register array of the host port with read-only slots.
`timescale 1ns/1ns
`default_nettype none
`include "lui_port_consts.vh"
module lui_reg_file #(
  parameter NREGS = `REG_COUNT
) (
  // Clock and control
  input  wire          i_sys_clk,
  input  wire          i_resetn,
  input  wire          i_ce,
  // Write side
  input  wire          i_wr_en,
  input  wire [4:0]    i_wr_addr,
  input  wire [7:0]    i_wr_data,
  // Read side
  input  wire [4:0]    i_rd_addr,
  output reg  [7:0]    o_rd_data,
  // Line-side status sources and control view
  input  wire [7:0]    i_line_status,
  input  wire [7:0]    i_receive_info_1,
  input  wire [7:0]    i_receive_info_2,
  input  wire [7:0]    i_error_count_1,
  input  wire [7:0]    i_error_count_2,
  output wire [8*NREGS-1:0] o_regs
);
  reg [7:0] regs_r [0:NREGS-1];
  integer k;

  function is_ro;
    input [4:0] a;
    begin
      is_ro = (a == `ADDR_LINE_STATUS) || (a == `ADDR_RECEIVE_INFO_1) ||
              (a == `ADDR_RECEIVE_INFO_2) || (a == `ADDR_ERROR_COUNT_1) ||
              (a == `ADDR_ERROR_COUNT_2);
    end
  endfunction

  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      for (k = 0; k < NREGS; k = k + 1) begin
        regs_r[k] <= `REG_RESET_VALUE;
      end
    end else if (i_ce) begin
      // Read-only and nonexistent addresses drop the write.
      if (i_wr_en && (i_wr_addr <= `ADDR_LAST_REG) && !is_ro(i_wr_addr)) begin
        regs_r[i_wr_addr] <= i_wr_data;
      end
    end
  end

  always @* begin
    if (i_rd_addr == `ADDR_LINE_STATUS) begin
      o_rd_data = i_line_status;
    end else if (i_rd_addr == `ADDR_RECEIVE_INFO_1) begin
      o_rd_data = i_receive_info_1;
    end else if (i_rd_addr == `ADDR_RECEIVE_INFO_2) begin
      o_rd_data = i_receive_info_2;
    end else if (i_rd_addr == `ADDR_ERROR_COUNT_1) begin
      o_rd_data = i_error_count_1;
    end else if (i_rd_addr == `ADDR_ERROR_COUNT_2) begin
      o_rd_data = i_error_count_2;
    end else if (i_rd_addr <= `ADDR_LAST_REG) begin
      o_rd_data = regs_r[i_rd_addr];
    end else begin
      o_rd_data = 8'h00;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NREGS; g = g + 1) begin : g_view
      assign o_regs[8*g+7:8*g] = regs_r[g];
    end
  endgenerate
endmodule // lui_reg_file
`default_nettype wire

// [lui_host_serial_port_props.sv]
// Concurrent checks on the host serial port pins.
`timescale 1ns/1ns
`default_nettype none
module lui_host_serial_port_props (
  // Clock and control
  input wire         i_sys_clk,
  input wire         i_resetn,
  // Straps and serial pins
  input wire         i_port_select_hi,
  input wire         i_port_select_lo,
  input wire         i_parallel_timing_style,
  input wire         i_cs_n,
  input wire         o_serial_out_oe,
  // Mode and register outputs
  input wire         o_serial_mode,
  input wire         o_parallel_mode,
  input wire         o_parallel_muxed,
  input wire         o_parallel_style_alt,
  input wire [175:0] o_regs
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // Straps held for five cycles have passed the synchronisers.
  sequence calm;
    ($stable(i_port_select_hi) && $stable(i_port_select_lo)
      && $stable(i_parallel_timing_style)) [*5];
  endsequence
  AST_SERIAL_SEL: assert property (calm |->
    o_serial_mode == (i_port_select_hi && !i_port_select_lo)) else $error("serial decode");
  AST_PAR_SEL: assert property (calm |-> o_parallel_mode == !i_port_select_hi)
    else $error("parallel decode");
  AST_MUXED: assert property (calm ##0 !i_port_select_hi |->
    o_parallel_muxed == !i_port_select_lo) else $error("muxed decode");
  AST_STYLE: assert property (calm ##0 !i_port_select_hi |->
    o_parallel_style_alt == i_parallel_timing_style) else $error("timing style");
  AST_OE_IDLE: assert property (i_cs_n [*5] |-> !o_serial_out_oe)
    else $error("output driven while deselected");
  AST_OE_MODE: assert property (o_serial_out_oe |-> o_serial_mode)
    else $error("output driven outside serial mode");
  AST_RO_ZERO: assert property (o_regs[55:48] == 8'h00 && o_regs[79:64] == 16'h0000
    && o_regs[151:136] == 16'h0000) else $error("read-only slot changed");
  AST_NO_WRITE_IDLE: assert property (i_cs_n [*5] |=> $stable(o_regs))
    else $error("register changed while deselected");
  cover property ($rose(o_serial_out_oe));
  cover property (!$stable(o_regs));
  cover property (o_parallel_mode && o_parallel_muxed);
endmodule // lui_host_serial_port_props
bind lui_host_serial_port lui_host_serial_port_props i_lui_host_serial_port_props (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_port_select_hi(i_port_select_hi),
  .i_port_select_lo(i_port_select_lo), .i_parallel_timing_style(i_parallel_timing_style),
  .i_cs_n(i_cs_n), .o_serial_out_oe(o_serial_out_oe), .o_serial_mode(o_serial_mode),
  .o_parallel_mode(o_parallel_mode), .o_parallel_muxed(o_parallel_muxed),
  .o_parallel_style_alt(o_parallel_style_alt), .o_regs(o_regs));
`default_nettype wire

// [lui_host_model.sv]
// Behavioural host that frames serial transfers to the port.
`timescale 1ns/1ns
`default_nettype none
module lui_host_model (
  // Clock and edge choice
  input  wire logic i_sys_clk,
  input  wire logic i_input_edge_select,
  input  wire logic i_output_edge_select,
  // Serial pins
  input  wire logic i_serial_out,
  output var  logic o_cs_n,
  output var  logic o_sclk,
  output var  logic o_serial_in
);
  logic [7:0] tx [0:23];
  logic [7:0] rx_byte;
  logic [7:0] sh;
  event       got;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_serial_in = 1'b0;
  end
  // Sends tx[0] onward for nbits input edges, then collects nrd read bytes.
  task automatic frame(input int nbits, input int nrd);
    int ie;
    int oe;
    int per;
    ie = 0;
    oe = 0;
    per = (nrd > 0) ? 10 + 8 * nrd : nbits;
    @(posedge i_sys_clk);
    o_cs_n <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    for (int p = 0; p < per; p++) begin
      for (int s = 0; s < 8; s++) begin
        @(negedge i_sys_clk);
        if (s == (i_output_edge_select ? 2 : 6)) begin
          if (oe > 0 && oe <= 8 * nrd) begin
            sh = {i_serial_out, sh[7:1]};
            if (oe % 8 == 0) begin
              rx_byte = sh;
              -> got;
            end
          end
          if (ie >= 8) oe++;
        end
        @(posedge i_sys_clk);
        if (s == (i_input_edge_select ? 4 : 0))
          o_serial_in <= (ie < nbits) ? tx[ie / 8][ie % 8] : ~o_serial_in;
        if (s == 2) o_sclk <= 1'b1;
        if (s == 6) o_sclk <= 1'b0;
        if (s == (i_input_edge_select ? 6 : 2)) ie++;
      end
    end
    repeat (4) @(posedge i_sys_clk);
    o_cs_n <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
  endtask
endmodule // lui_host_model
`default_nettype wire

// [lui_host_serial_port_tb.sv]
// Self-checking bench for the host serial port.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module lui_host_serial_port_tb;
  logic         i_sys_clk, i_resetn, hi, lo, sty, ies, oes, ce;
  wire          cs_n, sclk, sin, sout, soe, smode, pmode, pmux, palt;
  wire  [175:0] regs;
  logic [7:0]   mdl [0:21];
  logic [7:0]   expq [$];
  logic [7:0]   exp_b;
  logic [15:0]  seed;
  int           err_total, checks_done;
  localparam logic [21:0] RO = 22'h6_0340;
  // A released output line shows the inverse of the last driven bit.
  wire          sout_line = soe ? sout : ~sout;
  lui_host_serial_port i_lui_host_serial_port (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_ce(ce), .i_port_select_hi(hi), .i_port_select_lo(lo), .i_parallel_timing_style(sty),
    .i_input_edge_select(ies), .i_output_edge_select(oes), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_serial_in(sin), .o_serial_out(sout), .o_serial_out_oe(soe), .o_serial_mode(smode),
    .o_parallel_mode(pmode), .o_parallel_muxed(pmux), .o_parallel_style_alt(palt),
    .i_line_status(mdl[6]), .i_receive_info_1(mdl[8]), .i_receive_info_2(mdl[9]),
    .i_error_count_1(mdl[17]), .i_error_count_2(mdl[18]), .o_regs(regs));
  lui_host_model i_lui_host_model (.i_sys_clk(i_sys_clk), .i_input_edge_select(ies),
    .i_output_edge_select(oes), .i_serial_out(sout_line), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_serial_in(sin));
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  always @(i_lui_host_model.got) begin
    exp_b = expq.pop_front();
    `CHK(i_lui_host_model.rx_byte, exp_b)
  end
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  task automatic xfer(input logic [7:0] cmd, input int nbits, input int nrd);
    i_lui_host_model.tx[0] = cmd;
    i_lui_host_model.frame(nbits, nrd);
  endtask
  task automatic wr1(input logic [4:0] a, input logic [7:0] d);
    i_lui_host_model.tx[1] = d;
    if (a < 22 && !RO[a]) mdl[a] = d;
    xfer({2'h0, a, 1'b0}, 16, 0);
  endtask
  task automatic rd1(input logic [4:0] a);
    expq.push_back(a < 22 ? mdl[a] : 8'h00);
    xfer({2'h0, a, 1'b1}, 8, 1);
  endtask
  task automatic regs_chk();
    for (int a = 0; a < 22; a++) `CHK(regs[8*a +: 8], RO[a] ? 8'h00 : mdl[a])
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge i_sys_clk);
    err_total++;
    finish_test();
  end
  initial begin
    {hi, lo, sty, ies, oes, ce, i_resetn} = 7'h42;
    {seed, err_total, checks_done} = {16'h106e, 64'h0};
    for (int a = 0; a < 22; a++) mdl[a] = RO[a] ? rnd() : 8'h00;
    repeat (6) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    regs_chk();
    for (int m = 0; m < 8; m++) begin
      @(posedge i_sys_clk);
      {hi, lo, sty} <= m[2:0];
      repeat (6) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      `CHK(smode, hi & ~lo)
      `CHK(pmode, ~hi)
      if (!hi) `CHK({pmux, palt}, {~lo, sty})
    end
    $display("test modes done");
    for (int m = 0; m < 4; m++) begin
      @(posedge i_sys_clk);
      {hi, lo, ies, oes} <= {2'h2, m[1:0]};
      repeat (6) @(posedge i_sys_clk);
      wr1(5'(m * 7), rnd());
      rd1(5'(m * 7));
    end
    regs_chk();
    $display("test single done");
    wr1(5'h06, rnd());
    wr1(5'h16, rnd());
    rd1(5'h06);
    rd1(5'h16);
    rd1(5'h11);
    $display("test read only done");
    for (int a = 1; a < 24; a++) i_lui_host_model.tx[a] = rnd();
    for (int a = 0; a < 22; a++) if (!RO[a]) mdl[a] = i_lui_host_model.tx[a + 1];
    xfer(8'h80, 192, 0);
    regs_chk();
    for (int a = 0; a < 22; a++) expq.push_back(mdl[a]);
    xfer(8'h81, 8, 22);
    $display("test burst done");
    i_lui_host_model.tx[1] = ~mdl[0];
    xfer(8'h00, 12, 0);
    regs_chk();
    // A whole write frame with the clock enable low must leave every register as it was.
    ce <= 1'b0;
    xfer(8'h00, 16, 0);
    ce <= 1'b1;
    regs_chk();
    $display("test freeze done");
    for (int w = 0; w < 50 && expq.size() > 0; w++) @(posedge i_sys_clk);
    if (expq.size() > 0) err_total++;
    $display("test abort done");
    finish_test();
  end
endmodule // lui_host_serial_port_tb
`default_nettype wire
